// file: logic/mbc_regs.vh
`ifndef MBC_REGS_VH
`define MBC_REGS_VH

// Register indices (dword offsets); byte address is four times these
`define MBC_IDX_VERSION 4'h0
`define MBC_IDX_SPARE 4'h1
`define MBC_IDX_CONTROL 4'h2
`define MBC_IDX_ADDR_LO 4'h3
`define MBC_IDX_ADDR_HI 4'h4
`define MBC_IDX_MAX_FRM 4'h5
`define MBC_IDX_PAUSE 4'h6
`define MBC_IDX_RX_UPPER 4'h7
`define MBC_IDX_RX_FWD 4'h8
`define MBC_IDX_TX_UPPER 4'h9
`define MBC_IDX_LAST 4'h9

// Control word fields
`define MBC_CTL_TX_EN_BIT 0
`define MBC_CTL_RX_EN_BIT 1
`define MBC_CTL_ACCEPT_ALL_BIT 4

// Reset values, fixed forward level and FIFO margin
`define MBC_RST_ZERO 32'h0000_0000
`define MBC_RST_MAX_FRM 16'h05ee
`define MBC_FIXED_FWD 16'h0010
`define MBC_FIFO_MARGIN 16'h0010

`endif

// file: logic/mbc_base_config.v
`include "mbc_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module mbc_base_config #(
  parameter [15:0] CORE_VERSION = 16'h0001,
  // Arbitrary neutral value
  parameter [15:0] CUSTOMER_REVISION = 16'h0000,
  parameter REDUCED = 0,
  parameter [15:0] FIFO_DEPTH = 16'h0800
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire sw_reset,
  input wire congested,
  input wire [15:0] rx_frame_len,
  input wire rx_frame_len_valid,
  output reg mac_running,
  output reg rx_frame_too_long,
  output reg [15:0] pause_quanta,
  output reg [47:0] station_address,
  output reg accept_all_addresses,
  output reg [31:0] mac_control,
  output reg [15:0] max_frame_limit,
  output reg [15:0] rx_upper_level,
  output reg [15:0] rx_forward_level,
  output reg [15:0] tx_upper_level
);

  localparam [15:0] FIXED_UPPER = FIFO_DEPTH - `MBC_FIFO_MARGIN;

  reg [31:0] spare_reg;
  reg [31:0] control_reg;
  reg [31:0] addr_lo_reg;
  reg [31:0] addr_hi_reg;
  reg [15:0] max_frm_reg;
  reg [15:0] pause_reg;
  reg [15:0] rx_upper_reg;
  reg [15:0] rx_fwd_reg;
  reg [15:0] tx_upper_reg;
  reg wr_pend_reg;
  reg [3:0] wr_idx_reg;
  reg [31:0] rd_next;
  reg [15:0] max_frm_eff;
  reg [15:0] rx_upper_eff;
  reg [15:0] rx_fwd_eff;
  reg [15:0] tx_upper_eff;

  wire take = hsel & hready & htrans[1];
  wire addr_ok = (haddr[31:6] == 26'h0) && (haddr[5:2] <= `MBC_IDX_LAST);
  wire [3:0] idx = haddr[5:2];

  always @* begin
    if (REDUCED != 0) begin
      max_frm_eff = `MBC_RST_MAX_FRM;
      rx_upper_eff = FIXED_UPPER;
      tx_upper_eff = FIXED_UPPER;
      rx_fwd_eff = `MBC_FIXED_FWD;
    end else begin
      max_frm_eff = max_frm_reg;
      rx_upper_eff = rx_upper_reg;
      tx_upper_eff = tx_upper_reg;
      rx_fwd_eff = rx_fwd_reg;
    end
  end

  always @* begin
    rd_next = `MBC_RST_ZERO;
    if (addr_ok) begin
      case (idx)
        `MBC_IDX_VERSION: begin
          rd_next = {CUSTOMER_REVISION, CORE_VERSION};
        end
        `MBC_IDX_SPARE: begin
          rd_next = spare_reg;
        end
        `MBC_IDX_CONTROL: begin
          rd_next = control_reg;
        end
        `MBC_IDX_ADDR_LO: begin
          rd_next = addr_lo_reg;
        end
        `MBC_IDX_ADDR_HI: begin
          rd_next = addr_hi_reg;
        end
        `MBC_IDX_MAX_FRM: begin
          rd_next = {16'h0000, max_frm_eff};
        end
        `MBC_IDX_PAUSE: begin
          rd_next = {16'h0000, pause_reg};
        end
        `MBC_IDX_RX_UPPER: begin
          rd_next = {16'h0000, rx_upper_eff};
        end
        `MBC_IDX_RX_FWD: begin
          rd_next = {16'h0000, rx_fwd_eff};
        end
        `MBC_IDX_TX_UPPER: begin
          rd_next = {16'h0000, tx_upper_eff};
        end
        default: begin
          rd_next = `MBC_RST_ZERO;
        end
      endcase
    end
  end

  // Bus slave: zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `MBC_RST_ZERO;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 4'h0;
    end else begin
      wr_pend_reg <= take & hwrite & addr_ok;
      wr_idx_reg <= idx;
      if (take & ~hwrite) begin
        hrdata <= rd_next;
      end
    end
  end

  // Register storage; hardware reset, and sw_reset clears only the TX/RX enable bits
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spare_reg <= `MBC_RST_ZERO;
      control_reg <= `MBC_RST_ZERO;
      addr_lo_reg <= `MBC_RST_ZERO;
      addr_hi_reg <= `MBC_RST_ZERO;
      max_frm_reg <= `MBC_RST_MAX_FRM;
      pause_reg <= 16'h0000;
      rx_upper_reg <= 16'h0000;
      rx_fwd_reg <= 16'h0000;
      tx_upper_reg <= 16'h0000;
    end else begin
      if (wr_pend_reg) begin
        case (wr_idx_reg)
          `MBC_IDX_SPARE: begin
            spare_reg <= hwdata;
          end
          `MBC_IDX_CONTROL: begin
            control_reg <= hwdata;
          end
          `MBC_IDX_ADDR_LO: begin
            addr_lo_reg <= hwdata;
          end
          `MBC_IDX_ADDR_HI: begin
            addr_hi_reg <= {16'h0000, hwdata[15:0]};
          end
          `MBC_IDX_MAX_FRM: begin
            max_frm_reg <= hwdata[15:0];
          end
          `MBC_IDX_PAUSE: begin
            pause_reg <= hwdata[15:0];
          end
          `MBC_IDX_RX_UPPER: begin
            rx_upper_reg <= hwdata[15:0];
          end
          `MBC_IDX_RX_FWD: begin
            rx_fwd_reg <= hwdata[15:0];
          end
          `MBC_IDX_TX_UPPER: begin
            tx_upper_reg <= hwdata[15:0];
          end
          default: begin
            spare_reg <= spare_reg;
          end
        endcase
      end
      // Software reset wins over a same-cycle write of the enables
      if (sw_reset) begin
        control_reg[`MBC_CTL_TX_EN_BIT] <= 1'b0;
        control_reg[`MBC_CTL_RX_EN_BIT] <= 1'b0;
      end
    end
  end

  // Outputs toward the MAC datapath
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mac_running <= 1'b0;
      rx_frame_too_long <= 1'b0;
      pause_quanta <= 16'h0000;
      station_address <= 48'h0000_0000_0000;
      accept_all_addresses <= 1'b0;
      mac_control <= `MBC_RST_ZERO;
      max_frame_limit <= `MBC_RST_MAX_FRM;
      rx_upper_level <= 16'h0000;
      rx_forward_level <= 16'h0000;
      tx_upper_level <= 16'h0000;
    end else begin
      mac_running <= control_reg[`MBC_CTL_TX_EN_BIT] &
        control_reg[`MBC_CTL_RX_EN_BIT];
      rx_frame_too_long <= rx_frame_len_valid &&
        (rx_frame_len > max_frm_eff);
      if (REDUCED != 0) begin
        pause_quanta <= 16'h0000;
      end else if (congested) begin
        pause_quanta <= pause_reg;
      end else begin
        pause_quanta <= 16'h0000;
      end
      station_address <= {addr_hi_reg[15:0], addr_lo_reg};
      accept_all_addresses <= control_reg[`MBC_CTL_ACCEPT_ALL_BIT];
      mac_control <= control_reg;
      max_frame_limit <= max_frm_eff;
      rx_upper_level <= rx_upper_eff;
      rx_forward_level <= rx_fwd_eff;
      tx_upper_level <= tx_upper_eff;
    end
  end

endmodule

`default_nettype wire

// file: sim/mbc_base_config_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module mbc_base_config_asserts #(
  parameter [15:0] CORE_VERSION = 16'h0001,
  parameter [15:0] CUSTOMER_REVISION = 16'h0000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic sw_reset,
  input wire logic congested,
  input wire logic [15:0] rx_frame_len,
  input wire logic rx_frame_len_valid,
  input wire logic mac_running,
  input wire logic rx_frame_too_long,
  input wire logic [15:0] pause_quanta,
  input wire logic [31:0] mac_control,
  input wire logic [15:0] max_frame_limit
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire too = rx_frame_len > max_frame_limit;
  a_ver_read: assert property (rd && haddr == 32'h0
    |=> hrdata == {CUSTOMER_REVISION, CORE_VERSION}) else $error("bad version word");
  a_limit_upper: assert property (rd && haddr == 32'h14
    |=> hrdata[31:16] == 16'h0) else $error("limit upper bits set");
  a_run_both: assert property (mac_control[1:0] == 2'b11 |-> mac_running)
    else $error("mac not running");
  a_run_off: assert property (mac_control[1:0] != 2'b11 |-> !mac_running)
    else $error("mac running early");
  a_swrst_clear: assert property (sw_reset |-> ##2 mac_control[1:0] == 2'b00)
    else $error("enables kept");
  a_too_long: assert property (rx_frame_len_valid && too |=> rx_frame_too_long)
    else $error("long frame missed");
  a_not_long: assert property (rx_frame_len_valid && !too |=> !rx_frame_too_long)
    else $error("short frame flagged");
  a_pause_idle: assert property (!congested |=> pause_quanta == 16'h0)
    else $error("pause quanta while idle");
  c_swrst: cover property (sw_reset);
  c_long: cover property (rx_frame_too_long);
  c_run: cover property ($rose(mac_running));
endmodule
bind mbc_base_config mbc_base_config_asserts #(.CORE_VERSION(CORE_VERSION),
  .CUSTOMER_REVISION(CUSTOMER_REVISION)) u_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .sw_reset, .congested, .rx_frame_len,
  .rx_frame_len_valid, .mac_running, .rx_frame_too_long, .pause_quanta, .mac_control,
  .max_frame_limit);
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sw_reset = 0, congested = 0;
  logic rx_frame_len_valid = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] haddr = 0, hwdata = 0, r, m [0:15];
  logic [15:0] rx_frame_len = 0;
  wire [31:0] hrdata, mac_control;
  wire hreadyout, hresp, mac_running, rx_frame_too_long, accept_all_addresses;
  wire [15:0] pause_quanta, max_frame_limit, rx_upper_level, rx_forward_level, tx_upper_level;
  wire [47:0] station_address;
  int fails = 0, n_tests = 0;
  always #2 hclk = ~hclk;
  // Arbitrary customer revision
  mbc_base_config #(.CUSTOMER_REVISION(16'h3c5a)) u_dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .sw_reset, .congested, .rx_frame_len, .rx_frame_len_valid, .mac_running,
    .rx_frame_too_long, .pause_quanta, .station_address, .accept_all_addresses,
    .mac_control, .max_frame_limit, .rx_upper_level, .rx_forward_level, .tx_upper_level);
  task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d);
    hsel <= 1; htrans <= 2'b10; hwrite <= w; hsize <= 3'b010; haddr <= {26'h0, i, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    bus(1, i, d);
    if (i inside {[1:9]}) m[i] = (i inside {[4:9]}) ? {16'h0, d[15:0]} : d;
  endtask
  task automatic rd(input logic [3:0] i);
    bus(0, i, 32'h0);
    `CHK(r, m[i])
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    void'($urandom(6936));
    foreach (m[k]) m[k] = 32'h0;
    m[0] = {16'h3c5a, 16'h0001};
    m[5] = 32'h5ee;
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    for (int k = 0; k < 13; k++) rd(4'(k));
    for (int k = 0; k < 13; k++) wr(4'(k), $urandom);
    for (int k = 0; k < 13; k++) rd(4'(k));
    `CHK(rx_upper_level, m[7][15:0])
    `CHK(tx_upper_level, m[9][15:0])
    `CHK(rx_forward_level, m[8][15:0])
    wr(3, 32'h17231c00);
    wr(4, 32'hffffcb4a);
    wr(2, 32'h13);
    repeat (2) @(posedge hclk);
    `CHK(station_address, 48'hcb4a_1723_1c00)
    `CHK({mac_running, accept_all_addresses}, 2'b11)
    sw_reset <= 1;
    @(posedge hclk);
    sw_reset <= 0;
    m[2] &= ~32'h3;
    repeat (2) @(posedge hclk);
    `CHK(mac_running, 1'b0)
    for (int k = 0; k < 10; k++) rd(4'(k));
    wr(5, $urandom_range(1, 16'hfffe));
    repeat (2) @(posedge hclk);
    `CHK(max_frame_limit, m[5][15:0])
    for (int k = 0; k < 3; k++) begin
      rx_frame_len <= 16'(m[5][15:0] + k - 1);
      rx_frame_len_valid <= 1;
      @(posedge hclk);
      rx_frame_len_valid <= 0;
      #1;
      `CHK(rx_frame_too_long, k == 2)
      @(posedge hclk);
    end
    congested <= 1;
    repeat (3) @(posedge hclk);
    `CHK(pause_quanta, m[6][15:0])
    congested <= 0;
    repeat (3) @(posedge hclk);
    `CHK(pause_quanta, 16'h0)
    finish_test;
  end
  initial begin
    #20000;
    fails++;
    finish_test;
  end
endmodule
`default_nettype wire
